// >>> verif/tb_top.sv
// self-checking bench for the trunk egress port selector
`timescale 1ns/100ps
module tb_top;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rq;
  logic [63:0]        link_up;
  tps_pkg::tps_req_t  req, r;
  tps_pkg::tps_resp_t resp;
  int                 n_errors, total_checks;

  tps_trunk_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_up(link_up), .req(req), .resp(resp));
  tps_fwd_model u_fwd (.pclk(pclk), .req(req));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // edge first, so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog may end a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rq, exp);
  endtask

  task automatic wrd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b1, a, 32'hffff_ffff);
    rd(a, exp);
  endtask

  task automatic ent(input logic [6:0] e, input logic [3:0] w, input logic [31:0] d);
    apb(1'b1, tps_pkg::A_TSEL, {20'h0, w, 1'b0, e});
    apb(1'b1, tps_pkg::A_TDATA, d);
  endtask

  task automatic base(input logic [6:0] t, input int kind);
    r = '0;
    r.valid = 1'b1;
    r.trunk = t;
    r.known_uc = (kind == 0);
    r.known_mc = (kind == 1);
    r.flood = (kind == 2);
  endtask

  task automatic go(input logic [5:0] port, input logic [3:0] dev);
    int n;
    u_fwd.send(r);
    n = 0;
    while (resp.valid !== 1'b1 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    // valid is part of the word, so a missing answer cannot match stale fields
    chk({20'h0, resp.valid, resp.drop, resp.dev, resp.port}, {20'h0, 2'b10, dev, port});
  endtask

  function automatic logic [5:0] fold(input logic [127:0] k, input int s);
    logic [5:0]   h;
    logic [137:0] x;
    h = 6'h0;
    x = {10'h0, k} << s;
    for (int i = 0; i < 23; i++) h = h ^ x[i * 6 +: 6];
    return h;
  endfunction
  // ==========================================
  // tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    link_up = '1;
    n_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0);
    rd(12'h020, 32'h0);
    chk({31'h0, re}, 32'h1);
    wrd(tps_pkg::A_SHIFT, 32'h3fff_ffff);
    wrd(tps_pkg::A_GLOBAL, 32'h0000_0f13);
    wrd(tps_pkg::A_STACK, 32'h000f_ffff);
    wrd(tps_pkg::A_MASK0, 32'h0000_3fff);
    $display("test registers done");
    apb(1'b1, tps_pkg::A_SHIFT, 32'h0200_0002);
    apb(1'b1, tps_pkg::A_GLOBAL, 32'h0000_0500); // own device number 5, stacking mode off
    apb(1'b1, tps_pkg::A_STACK, 32'h0000_0300);
    apb(1'b1, tps_pkg::A_MASK0, 32'h0000_1001);
    apb(1'b1, tps_pkg::A_MASK1, 32'h0000_0002);
    for (int k = 0; k < 4; k++) ent(7'h0, 4'(k), 32'(2 * k + 1)); // members of distribution
    ent(7'h0, 4'h8, 32'h0000_0184);
    ent(7'h1, 4'h0, 32'h2);
    ent(7'h1, 4'h1, 32'h4);
    ent(7'h1, 4'h8, 32'h0000_0182);
    ent(7'h2, 4'h0, 32'h2);
    ent(7'h2, 4'h1, 32'h0000_0144);
    ent(7'h2, 4'h8, 32'h2);
    // member 7 is kept for separated traffic, so hashing spreads over 1, 3, 5
    for (int v = 0; v < 8; v++) begin
      base(7'h0, 0);
      r.source_physical_port = 6'(v);
      go(6'(2 * (fold(128'(v), 2) % 3) + 1), 4'h0);
      base(7'h0, 0);
      r.is_ip4 = v[0];
      r.is_ip6 = ~v[0];
      r.protocol = 8'(v * 41);
      go(6'(2 * (fold(128'(8'(v * 41)), 2) % 3) + 1), 4'h0);
    end
    $display("test hash done");
    base(7'h0, 2);
    go(6'd7, 4'h0);
    base(7'h0, 1);
    go(6'd7, 4'h0);
    apb(1'b1, tps_pkg::A_GLOBAL, 32'h0000_0502);
    base(7'h0, 1);
    go(6'd5, 4'h0);
    base(7'h0, 2);
    go(6'd7, 4'h0);
    base(7'h0, 0);
    r.source_physical_port = 6'd16;
    go(6'(2 * (fold(128'(16), 2) % 2) + 1), 4'h0);
    base(7'h1, 1);
    go(6'd4, 4'h0);
    link_up[4] <= 1'b0;
    base(7'h1, 1);
    go(6'd2, 4'h0);
    link_up[4] <= 1'b1;
    $display("test separation done");
    apb(1'b1, tps_pkg::A_GLOBAL, 32'h0000_0501);
    for (int v = 0; v < 4; v++) begin
      base(7'h0, 0);
      r.stack = 1'b1;
      r.stack_grp = 1'b1;
      r.source_physical_port = 6'(16 * v);
      go(6'(8 + fold(128'(16 * v), 2) % 2), 4'h5);
      r.known_uc = 1'b0;
      r.flood = 1'b1;
      go(6'(8 + fold(128'(16 * v), 2) % 2), 4'h5);
    end
    apb(1'b1, tps_pkg::A_STACK, 32'h000c_0300);
    for (int v = 0; v < 4; v++) begin
      base(7'h0, 0);
      r.stack = 1'b1;
      r.stack_grp = 1'b1;
      r.source_physical_port = 6'(16 * v);
      go(6'd8, 4'h5);
    end
    base(7'h2, 0);
    go(6'd2, 4'h0);
    apb(1'b1, tps_pkg::A_GLOBAL, 32'h0000_0511);
    base(7'h2, 0);
    go(6'd4, 4'h5);
    base(7'h2, 1);
    go(6'd2, 4'h0);
    $display("test stacking done");
    complete_run;
  end

  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    $display("BAD %0t timeout", $time);
    complete_run;
  end
endmodule

// >>> verif/tps_chk.sv
// assertion checker on the ports of the trunk egress port selector
`timescale 1ns/100ps
module tps_chk (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [63:0]        link_up,
  input wire tps_pkg::tps_req_t  req,
  input wire tps_pkg::tps_resp_t resp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // register bus
  AST_ACK_NEXT: assert property (psel && penable && !pready |=> pready)
    else $error("register answer late");
  AST_ACK_PULSE: assert property (pready |=> !pready)
    else $error("register answer held");
  AST_ACK_CAUSE: assert property (!(psel && penable) |=> !pready)
    else $error("register answer without access");
  AST_ERR_MAP: assert property (psel && penable && !pready
    && (paddr >= 12'h020 || paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_OK_MAP: assert property (psel && penable && !pready
    && paddr < 12'h020 && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access refused");
  // ==========================================
  // member selection, fixed two-cycle pipeline
  AST_RESP_LAT: assert property (req.valid |-> ##2 resp.valid)
    else $error("answer missing");
  AST_RESP_CAUSE: assert property (resp.valid |-> $past(req.valid, 2))
    else $error("answer without request");
  // stacking answers index the stacking port of the requested group
  AST_STK_PORT: assert property (resp.valid && !resp.drop && $past(req.stack, 2) |->
    resp.port[5:3] == {2'b00, $past(req.stack_grp, 2)})
    else $error("stacking port outside its group");
endmodule

bind tps_trunk_select tps_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .link_up(link_up), .req(req), .resp(resp));

// >>> verif/tps_fwd_model.sv
// forwarding pipeline model that hands requests to the selector
`timescale 1ns/100ps
module tps_fwd_model (
  input wire logic          pclk,
  output tps_pkg::tps_req_t req
);
  tps_pkg::tps_req_t idle;
  initial req = '0;
  // ==========================================
  // one request, valid for exactly one cycle
  task automatic send(input tps_pkg::tps_req_t r);
    begin
      req <= r;
      @(posedge pclk);
      // inverted fields after release so stale data cannot pass for a match
      idle = ~r;
      idle.valid = 1'b0;
      req <= idle;
    end
  endtask
endmodule

// >>> verilog/tps_key_fold.sv
// shifts one hash key and folds it into a 6-bit chunk xor
`timescale 1ns/100ps
module tps_key_fold (
  input  wire logic [127:0] key,
  input  wire logic [2:0]   amt,
  input  wire logic         en,
  output logic      [5:0]   hash
);
  logic [137:0] wide;
  logic [5:0]   acc;

  // ==========================================
  // shift then fold
  always_comb begin
    wide = '0;
    wide[134:0] = {7'h0, key} << amt;
    acc = '0;
    for (int i = 0; i < 23; i++) begin
      acc = acc ^ wide[i*6 +: 6];
    end
    hash = en ? acc : 6'h00;
  end
endmodule

// >>> verilog/tps_pkg.sv
// constants and carrier types for the trunk egress port selector
package tps_pkg;
  // ==========================================
  // sizes
  localparam int KEYS    = 10;
  localparam int KEY_W   = 128;
  localparam int SH_W    = 3;
  localparam int HASH_W  = 6;
  localparam int CAND    = 8;
  localparam int ENTRIES = 128;
  localparam int STK_GRP = 8;
  // ==========================================
  // register byte addresses
  localparam logic [11:0] A_SHIFT  = 12'h000;
  localparam logic [11:0] A_GLOBAL = 12'h004;
  localparam logic [11:0] A_STACK  = 12'h008;
  localparam logic [11:0] A_MASK0  = 12'h00c;
  localparam logic [11:0] A_MASK1  = 12'h010;
  localparam logic [11:0] A_TSEL   = 12'h014;
  localparam logic [11:0] A_TDATA  = 12'h018;
  localparam logic [11:0] A_STAT   = 12'h01c;
  // ==========================================
  // field positions
  localparam int G_STACK_MODE  = 0;
  localparam int G_SEP_SEL     = 1;
  localparam int G_LOCAL_FIRST = 4;
  localparam int G_MY_DEV      = 8;
  localparam int S_RECOMPUTE   = 19;
  localparam int S_L2_IDX      = 18;
  localparam int S_IP4_IDX     = 17;
  localparam int S_IP6_IDX     = 16;
  localparam int M_L3_LSB      = 4;
  localparam int T_WORD_LSB    = 8;
  localparam int E_L2_IDX      = 4;
  localparam int E_IP4_IDX     = 5;
  localparam int E_IP6_IDX     = 6;
  localparam int E_SEP_FLOOD   = 7;
  localparam int E_SEP_MC      = 8;
  localparam logic [3:0] W_CTRL = 4'h8;
  // ==========================================
  // reset values
  localparam logic [31:0] RST_SHIFT  = 32'h0000_0000;
  localparam logic [31:0] RST_GLOBAL = 32'h0000_0000;
  localparam logic [31:0] RST_STACK  = 32'h0000_0000;
  localparam logic [13:0] RST_MASK   = 14'h0000;
  // ==========================================
  // fixed keys for traffic other than known unicast
  localparam logic [9:0] FIXED_L2 = 10'h007;
  localparam logic [9:0] FIXED_L3 = 10'h031;

  typedef struct packed {
    logic         valid;
    logic [6:0]   trunk;
    logic         stack;
    logic         stack_grp;
    logic         known_uc;
    logic         known_mc;
    logic         flood;
    logic         is_ip4;
    logic         is_ip6;
    logic [5:0]   source_physical_port;
    logic [47:0]  smac;
    logic [47:0]  dmac;
    logic [11:0]  vlan;
    logic [127:0] sip;
    logic [127:0] dip;
    logic [15:0]  l4_src;
    logic [15:0]  l4_dst;
    logic [7:0]   protocol;
    logic [19:0]  flow_label;
  } tps_req_t;

  typedef struct packed {
    logic       valid;
    logic       drop;
    logic [3:0] dev;
    logic [5:0] port;
  } tps_resp_t;
endpackage

// >>> verilog/tps_trunk_select.sv
// trunk egress member selection with apb register file
//
// How it works
// - each selected key folds into 6-bit chunks, all xored to one hash
// - 3-bit shifts for port, smac, dmac, vlan, sip, dip at bits 17:0
// - 3-bit shifts for l4 ports, protocol, flow label at bits 29:18
// - a key shifts upward before folding, low bits zero filled
// - separated multicast or flood goes to the largest up member
// - each trunk entry has flood and known multicast separation enables
// - both enabled and select set: known multicast to second largest
// - members dedicated to separation leave the hash pool
// - with only two members known multicast stays on the largest
// - separation suspended with zero or one link-up member, or zero or one member in stacking mode
// - global bit 4 picks local-first balancing in stacking mode
// - only known unicast uses local-first; others follow the hash
// - two stacking trunk groups, hash shared over their members
// - stacking option reuses trunk hash or recomputes with own indexes
// - stacking mask index bits 18, 17, 16 for l2, ipv4, ipv6
// - 16-bit stacking member mask, one marks an aggregated port
// - stacking trunks skip separation but keep key shifts
// - 4-bit l2 and 10-bit l3 key masks, two sets each
// - egress entry holds eight device-port candidates and a count
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
module tps_trunk_select (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [63:0]       link_up,
  input  wire tps_pkg::tps_req_t req,
  output tps_pkg::tps_resp_t     resp
);
  // ==========================================
  // registers
  logic [31:0] shift_ff;
  logic [31:0] global_ff;
  logic [31:0] stack_ff;
  logic [13:0] mask_ff [2];
  logic [11:0] tsel_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [9:0]  cand_mem [tps_pkg::ENTRIES*tps_pkg::CAND];
  logic [8:0]  ctl_mem [tps_pkg::ENTRIES];
  tps_pkg::tps_req_t  req_ff;
  logic [9:0]         cand_ff [tps_pkg::CAND];
  logic [8:0]         ctl_ff;
  tps_pkg::tps_resp_t resp_ff;
  logic [3:0]         upcnt_ff;

  logic [31:0] nxt_prdata;
  logic        hit;
  logic        wr_en;
  logic [6:0]  t_ent;
  logic [3:0]  t_word;
  logic [9:0]  t_addr;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign resp    = resp_ff;

  assign t_ent  = tsel_ff[6:0];
  assign t_word = tsel_ff[tps_pkg::T_WORD_LSB +: 4];
  assign t_addr = {t_ent, t_word[2:0]};
  assign wr_en  = psel & penable & pwrite & pready_ff & hit;

  // ==========================================
  // apb read decode
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      tps_pkg::A_SHIFT:  nxt_prdata = {2'b00, shift_ff[29:0]};
      tps_pkg::A_GLOBAL: nxt_prdata = global_ff;
      tps_pkg::A_STACK:  nxt_prdata = stack_ff;
      tps_pkg::A_MASK0:  nxt_prdata = {18'h0, mask_ff[0]};
      tps_pkg::A_MASK1:  nxt_prdata = {18'h0, mask_ff[1]};
      tps_pkg::A_TSEL:   nxt_prdata = {20'h0, tsel_ff};
      tps_pkg::A_TDATA: begin
        if (t_word < tps_pkg::W_CTRL) begin
          nxt_prdata = {22'h0, cand_mem[t_addr]};
        end else if (t_word == tps_pkg::W_CTRL) begin
          nxt_prdata = {23'h0, ctl_mem[t_ent]};
        end
      end
      tps_pkg::A_STAT: begin
        nxt_prdata = {16'h0, upcnt_ff, resp_ff.drop,
                      resp_ff.dev, resp_ff.port, resp_ff.valid};
      end
      default: hit = 1'b0;
    endcase
  end

  // ==========================================
  // apb handshake: one wait cycle, answer from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (psel & penable & ~pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= ~hit;
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ff  <= tps_pkg::RST_SHIFT;
      global_ff <= tps_pkg::RST_GLOBAL;
      stack_ff  <= tps_pkg::RST_STACK;
      mask_ff[0] <= tps_pkg::RST_MASK;
      mask_ff[1] <= tps_pkg::RST_MASK;
      tsel_ff   <= 12'h000;
    end else if (wr_en) begin
      case (paddr)
        tps_pkg::A_SHIFT:  shift_ff <= {2'b00, pwdata[29:0]};
        tps_pkg::A_GLOBAL: begin
          global_ff <= {20'h0, pwdata[11:8], 3'b000,
                        pwdata[4], 2'b00, pwdata[1:0]};
        end
        tps_pkg::A_STACK:  stack_ff <= {12'h0, pwdata[19:0]};
        tps_pkg::A_MASK0:  mask_ff[0] <= pwdata[13:0];
        tps_pkg::A_MASK1:  mask_ff[1] <= pwdata[13:0];
        tps_pkg::A_TSEL:   tsel_ff <= {pwdata[11:8], 1'b0, pwdata[6:0]};
        default: ;
      endcase
    end
  end

  // ==========================================
  // egress trunk table, written indirectly; no reset on storage
  always_ff @(posedge pclk) begin
    if (wr_en && paddr == tps_pkg::A_TDATA) begin
      if (t_word < tps_pkg::W_CTRL) begin
        cand_mem[t_addr] <= pwdata[9:0];
      end else if (t_word == tps_pkg::W_CTRL) begin
        ctl_mem[t_ent] <= pwdata[8:0];
      end
    end
  end

  // ==========================================
  // stage 1: take request, fetch its trunk entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= '0;
      ctl_ff <= 9'h000;
      for (int k = 0; k < tps_pkg::CAND; k++) begin
        cand_ff[k] <= 10'h000;
      end
    end else begin
      req_ff <= req;
      ctl_ff <= ctl_mem[req.trunk];
      for (int k = 0; k < tps_pkg::CAND; k++) begin
        cand_ff[k] <= cand_mem[{req.trunk, 3'(k)}];
      end
    end
  end

  // ==========================================
  // helpers
  function automatic logic [3:0] pop8(input logic [7:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + {3'b000, m[i]};
    end
    return c;
  endfunction

  function automatic logic [2:0] top8(input logic [7:0] m);
    logic [2:0] t;
    t = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        t = 3'(i);
      end
    end
    return t;
  endfunction

  function automatic logic [2:0] nth8(input logic [7:0] m, input logic [2:0] n);
    logic [2:0] t;
    logic [3:0] c;
    t = 3'h0;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        if (c == {1'b0, n}) begin
          t = 3'(i);
        end
        c = c + 4'h1;
      end
    end
    return t;
  endfunction

  // ==========================================
  // key mask choice
  logic        use_stk_idx;
  logic        set_idx;
  logic [13:0] mset;
  logic [9:0]  kmask;

  assign use_stk_idx = req_ff.stack & stack_ff[tps_pkg::S_RECOMPUTE];

  always_comb begin
    if (req_ff.is_ip6) begin
      set_idx = use_stk_idx ? stack_ff[tps_pkg::S_IP6_IDX]
                            : ctl_ff[tps_pkg::E_IP6_IDX];
    end else if (req_ff.is_ip4) begin
      set_idx = use_stk_idx ? stack_ff[tps_pkg::S_IP4_IDX]
                            : ctl_ff[tps_pkg::E_IP4_IDX];
    end else begin
      set_idx = use_stk_idx ? stack_ff[tps_pkg::S_L2_IDX]
                            : ctl_ff[tps_pkg::E_L2_IDX];
    end
    mset = mask_ff[set_idx];
    if (!req_ff.known_uc) begin
      kmask = (req_ff.is_ip4 | req_ff.is_ip6) ? tps_pkg::FIXED_L3 : tps_pkg::FIXED_L2;
    end else if (req_ff.is_ip4 | req_ff.is_ip6) begin
      kmask = mset[tps_pkg::M_L3_LSB +: 10];
    end else begin
      kmask = {6'h00, mset[3:0]};
    end
  end

  // ==========================================
  // hash: per key shift and fold, shared by trunk and stacking paths
  logic [127:0] key_vec [tps_pkg::KEYS];
  logic [5:0]   key_hash [tps_pkg::KEYS];
  logic [5:0]   hash;

  assign key_vec[0] = 128'(req_ff.source_physical_port);
  assign key_vec[1] = 128'(req_ff.smac);
  assign key_vec[2] = 128'(req_ff.dmac);
  assign key_vec[3] = 128'(req_ff.vlan);
  assign key_vec[4] = req_ff.sip;
  assign key_vec[5] = req_ff.dip;
  assign key_vec[6] = 128'(req_ff.l4_src);
  assign key_vec[7] = 128'(req_ff.l4_dst);
  assign key_vec[8] = 128'(req_ff.protocol);
  assign key_vec[9] = 128'(req_ff.flow_label);

  for (genvar g = 0; g < tps_pkg::KEYS; g++) begin : g_key
    tps_key_fold u_fold (
      .key  (key_vec[g]),
      .amt  (shift_ff[g*tps_pkg::SH_W +: tps_pkg::SH_W]),
      .en   (kmask[g]),
      .hash (key_hash[g])
    );
  end

  always_comb begin
    hash = 6'h00;
    for (int i = 0; i < tps_pkg::KEYS; i++) begin
      hash = hash ^ key_hash[i];
    end
  end

  // ==========================================
  // trunk member choice
  logic [7:0] up;
  logic [7:0] resv;
  logic [7:0] pool;
  logic [7:0] lpool;
  logic [7:0] fin;
  logic [3:0] n_up;
  logic [3:0] n_fin;
  logic [2:0] big;
  logic [2:0] second;
  logic [2:0] pick;
  logic       sep_ok;
  logic       en_fl;
  logic       en_mc;
  logic       mc2;
  logic       stk_mode;
  logic [3:0] my_dev;

  assign stk_mode = global_ff[tps_pkg::G_STACK_MODE];
  assign my_dev   = global_ff[tps_pkg::G_MY_DEV +: 4];
  assign en_fl    = ctl_ff[tps_pkg::E_SEP_FLOOD];
  assign en_mc    = ctl_ff[tps_pkg::E_SEP_MC];

  always_comb begin
    for (int k = 0; k < tps_pkg::CAND; k++) begin
      // remote link state is unknown in stacking mode, software fails over
      up[k] = (4'(k) < ctl_ff[3:0]) &
              (stk_mode | link_up[cand_ff[k][5:0]]);
      lpool[k] = 1'b0;
    end
    n_up   = pop8(up);
    big    = top8(up);
    second = top8(up & ~(8'h01 << big));
    sep_ok = (n_up > 4'h1) & ~req_ff.stack;
    mc2    = en_fl & en_mc & global_ff[tps_pkg::G_SEP_SEL]
           & (n_up > 4'h2);
    resv = 8'h00;
    if (sep_ok & (en_fl | en_mc)) begin
      resv = (8'h01 << big) | (mc2 ? (8'h01 << second) : 8'h00);
    end
    pool = up & ~resv;
    for (int k = 0; k < tps_pkg::CAND; k++) begin
      lpool[k] = pool[k] & (cand_ff[k][9:6] == my_dev);
    end
    fin = pool;
    if (stk_mode & global_ff[tps_pkg::G_LOCAL_FIRST] & req_ff.known_uc
        & (|lpool)) begin
      fin = lpool;
    end
    n_fin = pop8(fin);
    pick  = 3'h0;
    if (n_fin != 4'h0) begin
      pick = nth8(fin, 3'(hash % {2'b00, n_fin}));
    end
    if (sep_ok & req_ff.flood & en_fl) begin
      pick = big;
    end else if (sep_ok & req_ff.known_mc & en_mc) begin
      pick = mc2 ? second : big;
    end
  end

  // ==========================================
  // stacking trunk choice
  logic [7:0] smem;
  logic [3:0] n_stk;
  logic [2:0] spick;

  always_comb begin
    smem  = stack_ff[req_ff.stack_grp*tps_pkg::STK_GRP +: 8];
    n_stk = pop8(smem);
    spick = 3'h0;
    if (n_stk != 4'h0) begin
      spick = nth8(smem, 3'(hash % {2'b00, n_stk}));
    end
  end

  // ==========================================
  // stage 2: registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_ff  <= '0;
      upcnt_ff <= 4'h0;
    end else begin
      resp_ff.valid <= req_ff.valid;
      if (req_ff.stack) begin
        resp_ff.drop <= (n_stk == 4'h0);
        resp_ff.dev  <= my_dev;
        resp_ff.port <= {2'b00, req_ff.stack_grp, spick};
      end else begin
        resp_ff.drop <= (n_up == 4'h0);
        resp_ff.dev  <= cand_ff[pick][9:6];
        resp_ff.port <= cand_ff[pick][5:0];
      end
      if (req_ff.valid) begin
        upcnt_ff <= n_up;
      end
    end
  end
endmodule
